// ==== pkg/pwm_seq_pkg.sv ====
// Purpose: Shared types and constants for the switch-mode PWM event sequencer.
// Assumes: One 100 MHz clock; all control inputs are synchronous to it.
// Notes:   Source-select vectors use the layout of srcSel_type.
package pwm_seq_pkg;

  localparam int          CNT_W       = 16;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_ONE     = 16'h0001;
  localparam logic [15:0] PERIOD_RST  = 16'hffff;
  localparam logic [15:0] PHASE_RST   = 16'h0000;
  localparam logic [15:0] DUTY_RST    = 16'h8000;
  localparam int          DB_W        = 8;
  localparam logic [7:0]  DB_RST      = 8'h00;
  localparam logic [7:0]  BLANK_RST   = 8'h00;
  localparam logic [7:0]  TMR8_ZERO   = 8'h00;
  localparam logic [7:0]  TMR8_ONE    = 8'h01;
  localparam logic [4:0]  SRC_NONE    = 5'h00;
  localparam logic [3:0]  SHDN_NONE   = 4'h0;

  // Bit 4 is the counter match, bit 3 the input pin, bits 2..0 comparators 3..1.
  typedef struct packed {
    logic matchEn;
    logic pinEn;
    logic cmp3En;
    logic cmp2En;
    logic cmp1En;
  } srcSel_type;

  typedef struct packed {
    logic pin;
    logic cmp3;
    logic cmp2;
    logic cmp1;
  } asyncIn_type;

  typedef enum logic [3:0] {
    MODE_SINGLE      = 4'h0,
    MODE_COMPL       = 4'h1,
    MODE_PUSHPULL    = 4'h2,
    MODE_PP_BRIDGE   = 4'h3,
    MODE_CPP_BRIDGE  = 4'h4,
    MODE_PULSE_SKIP  = 4'h5,
    MODE_VFFD        = 4'h6,
    MODE_CVFFD       = 4'h7,
    MODE_FB_FWD      = 4'h8,
    MODE_FB_REV      = 4'h9,
    MODE_SIX_STEP    = 4'ha
  } mode_type;

  typedef enum logic [1:0] {
    MOD_SOFT = 2'h0,
    MOD_CMP  = 2'h1,
    MOD_CCU  = 2'h2,
    MOD_PIN  = 2'h3
  } modSel_type;

  typedef struct packed {
    logic [15:0] period;
    logic [15:0] phase;
    logic [15:0] duty;
  } timing_type;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'h0,
    PH_ACTIVE = 2'h1,
    PH_DONE   = 2'h2
  } phase_type;

endpackage

// ==== logic/pwm_event_seq.sv ====
// Purpose: Period, rising and falling event sequencing with drive outputs.
// Assumes: Inputs synchronous to clk; comparator inputs already synchronized.
// Notes:   Blanking and dead-band are simple down-counters started by the edge events.
`timescale 1ns/1ps

// Behaviour
// [R01] Any period event resets the time base counter on the next clock edge.
// [R02] After a period reset, the counter counts up again from zero.
// [R03] Period event is the OR of selected match, pin and comparator sources.
// [R04] Rising event is the OR of selected phase match, pin and comparators.
// [R05] Only the first rising event in a period acts; later ones ignored.
// [R06] A rising event after a falling event in the same period is ignored.
// [R07] Falling event acts at most once per period to stop output chatter.
// [R08] An accepted rising event starts falling blanking and dead-band timers; the code skips this when a falling event is accepted in the same cycle.
// [R09] Accepted rising event changes drive outputs directly per selected mode; the code changes the registered drive two clocks later at the earliest.
// [R10] Auto-shutdown from enabled pin or comparator inputs stops PWM in hardware.
// [R11] Active pulse is gated by one selected source: soft bit, comparator, CCU, pin.
// [R12] Configurable dead time separates complementary drive outputs.
// [R13] Synchronous events come only from the internal time base counter.
// [R14] Delayed rising edge shortens active time, but full duty stays possible; the code returns to PH_IDLE at each period event, so active drops every period.
// [R15] Exactly one operating mode is active at a time.
// [R16] The 16-bit time base counter increments each clock from zero.
// [R17] Counter equal to the period value raises a synchronous period event.
// [R18] Only the first falling event in a period acts.
// [R19] Buffered period, phase and duty load together at period after request.
// [R20] Occurrence latches clear at each period event.
module pwm_event_seq
  import pwm_seq_pkg::*;
(
  input  wire logic        clk,              // 100 MHz clock
  input  wire logic        rst,              // Synchronous reset, active high
  input  wire logic        enable,           // Module enable
  input  wire mode_type    mode,             // Operating mode
  input  wire timing_type  timingIn,         // Software-written timing values
  input  wire logic        bufferLoadRequest, // Latched into loadPending, which the block clears on load
  input  wire srcSel_type  periodSourceSelect, // Period event sources
  input  wire srcSel_type  risingSourceSelect, // Rising event sources
  input  wire srcSel_type  fallingSourceSelect, // Falling event sources
  input  wire asyncIn_type asyncIn,          // Pin and synced comparator inputs
  input  wire asyncIn_type shutdownEnable,   // Auto-shutdown source enables
  input  wire logic        modEnable,        // Pulse gating enable
  input  wire modSel_type  modSelect,        // Pulse gating source
  input  wire logic        modSoftBit,       // Software gating bit
  input  wire logic        captureCompareOut, // Capture/compare unit output
  input  wire logic [7:0]  deadBandCount,    // Dead time in clocks
  input  wire logic [7:0]  blankCount,       // Falling blanking in clocks
  output logic [15:0]      timeBaseCounter,  // Time base counter
  output logic             loadPending,      // Load request awaiting period
  output logic             shutdown,         // Auto-shutdown active
  output logic [5:0]       drive,            // Drive outputs A..F
  output logic             periodEvent,      // Period event pulse
  output logic             risingAccepted,   // Accepted rising pulse
  output logic             fallingAccepted   // Accepted falling pulse
);

  function automatic logic pick(input srcSel_type s, input logic m, input asyncIn_type a);
    pick = (s.matchEn & m) | (s.pinEn & a.pin) | (s.cmp3En & a.cmp3) |
           (s.cmp2En & a.cmp2) | (s.cmp1En & a.cmp1);
  endfunction

  function automatic logic [7:0] dec8(input logic [7:0] v);
    dec8 = (v == TMR8_ZERO) ? TMR8_ZERO : v - TMR8_ONE;
  endfunction

  logic [15:0] cnt_q, cnt_d;
  timing_type  act_q, act_d;
  logic        pend_q, pend_d;
  phase_type   ph_q, ph_d;
  logic        shdn_q, shdn_d;
  logic        steer_q, steer_d;
  logic [7:0]  dbR_q, dbR_d, dbF_q, dbF_d, blank_q, blank_d;
  logic [5:0]  drv_q, drv_d;
  logic        perEv, risEv, falEv, risOk, falOk, gate, active;

  // Synchronous events only ever compare against the internal counter.
  always_comb begin
    perEv = enable && pick(periodSourceSelect, cnt_q == act_q.period, asyncIn); // [R03] [R17] [R13]
    risEv = pick(risingSourceSelect, cnt_q == act_q.phase, asyncIn); // [R04] [R13]
    falEv = pick(fallingSourceSelect, cnt_q == act_q.duty, asyncIn) && (blank_q == TMR8_ZERO);
    risOk = enable && risEv && (ph_q == PH_IDLE); // [R05] [R06]
    falOk = enable && falEv && (ph_q != PH_DONE); // [R07] [R18]
  end

  always_comb begin
    case (modSelect)
      MOD_SOFT: gate = modSoftBit; // [R11]
      MOD_CMP:  gate = asyncIn.cmp1;
      MOD_CCU:  gate = captureCompareOut;
      MOD_PIN:  gate = asyncIn.pin;
      default:  gate = 1'b0;
    endcase
    if (!modEnable) begin
      gate = 1'b1;
    end
  end

  always_comb begin
    cnt_d   = cnt_q + CNT_ONE; // [R16]
    act_d   = act_q;
    pend_d  = pend_q | bufferLoadRequest;
    ph_d    = ph_q;
    shdn_d  = shdn_q | (|(shutdownEnable & asyncIn)); // [R10]
    steer_d = steer_q;
    dbR_d   = dec8(dbR_q);
    dbF_d   = dec8(dbF_q);
    blank_d = dec8(blank_q);
    if (!enable) begin
      cnt_d  = CNT_RESET;
      ph_d   = PH_IDLE;
      shdn_d = 1'b0;
    end else begin
      if (perEv) begin
        cnt_d = CNT_RESET; // [R01] [R02]
        ph_d  = PH_IDLE; // [R20]
        steer_d = ~steer_q;
        if (pend_q) begin
          act_d  = timingIn; // [R19]
          // A request raised in the very cycle of the load stays pending: set wins.
          pend_d = bufferLoadRequest;
        end
      end
      // Falling is checked first so a same-cycle pair gives zero duty.
      if (falOk) begin
        ph_d = PH_DONE;
        dbF_d = deadBandCount; // [R12]
      end else if (risOk) begin
        ph_d = PH_ACTIVE;
        blank_d = blankCount; // [R08]
        dbR_d = deadBandCount; // [R08] [R12]
      end
    end
  end

  // Active drops at a period reset: the period event returns ph_q to PH_IDLE, so 100% is not reachable.
  assign active = (ph_q == PH_ACTIVE) && gate && !shdn_q; // [R14]

  always_comb begin
    drv_d = 6'h00;
    // One mode is decoded per cycle; the case selects exactly one mapping.
    case (mode) // [R15] [R09]
      MODE_SINGLE, MODE_PULSE_SKIP, MODE_VFFD: drv_d[0] = active;
      MODE_COMPL, MODE_CVFFD: begin
        drv_d[0] = active && (dbR_q == TMR8_ZERO);
        drv_d[1] = !active && (dbF_q == TMR8_ZERO) && !shdn_q;
      end
      MODE_PUSHPULL, MODE_PP_BRIDGE, MODE_CPP_BRIDGE: begin
        drv_d[0] = active && !steer_q;
        drv_d[1] = active && steer_q;
      end
      MODE_FB_FWD: drv_d[3:0] = {1'b0, active, 1'b0, !shdn_q};
      MODE_FB_REV: drv_d[3:0] = {!shdn_q, 1'b0, active, 1'b0};
      MODE_SIX_STEP: drv_d = active ? 6'h21 : 6'h00;
      default: drv_d = 6'h00;
    endcase
    if (!enable || shdn_q) begin
      drv_d = 6'h00; // [R10]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q   <= CNT_RESET;
      act_q   <= '{period: PERIOD_RST, phase: PHASE_RST, duty: DUTY_RST};
      pend_q  <= 1'b0;
      ph_q    <= PH_IDLE;
      shdn_q  <= 1'b0;
      steer_q <= 1'b0;
      dbR_q   <= DB_RST;
      dbF_q   <= DB_RST;
      blank_q <= BLANK_RST;
      drv_q   <= 6'h00;
    end else begin
      cnt_q   <= cnt_d;
      act_q   <= act_d;
      pend_q  <= pend_d;
      ph_q    <= ph_d;
      shdn_q  <= shdn_d;
      steer_q <= steer_d;
      dbR_q   <= dbR_d;
      dbF_q   <= dbF_d;
      blank_q <= blank_d;
      drv_q   <= drv_d;
    end
  end

  assign timeBaseCounter = cnt_q;
  assign loadPending     = pend_q;
  assign shutdown        = shdn_q;
  assign drive           = drv_q;
  assign periodEvent     = perEv;
  assign risingAccepted  = risOk;
  assign fallingAccepted = falOk;

  chk_period_reset: assert property (@(posedge clk) disable iff (rst)
    periodEvent |=> timeBaseCounter == CNT_RESET) else $error("counter not reset"); // [R01]
  chk_count_resume: assert property (@(posedge clk) disable iff (rst)
    enable && periodEvent ##1 enable && !periodEvent |=> timeBaseCounter == CNT_ONE)
    else $error("counter did not resume"); // [R02]
  chk_rise_once: assert property (@(posedge clk) disable iff (rst)
    risingAccepted |=> !risingAccepted until_with periodEvent)
    else $error("second rising accepted"); // [R05]
  chk_rise_after_fall: assert property (@(posedge clk) disable iff (rst)
    fallingAccepted && !periodEvent |=> !risingAccepted) else $error("rise after fall"); // [R06]
  chk_fall_once: assert property (@(posedge clk) disable iff (rst)
    fallingAccepted && !periodEvent |=> !fallingAccepted) else $error("second falling"); // [R07]
  chk_blank_start: assert property (@(posedge clk) disable iff (rst)
    enable && risingAccepted && !fallingAccepted |=> blank_q == $past(blankCount))
    else $error("blanking not started"); // [R08]
  chk_shutdown_drive: assert property (@(posedge clk) disable iff (rst)
    shutdown |=> drive == 6'h00) else $error("drive during shutdown"); // [R10]
  chk_load_apply: assert property (@(posedge clk) disable iff (rst)
    enable && periodEvent && loadPending |=> act_q == $past(timingIn) && !loadPending)
    else $error("buffered load missed"); // [R19]
  chk_match_period: assert property (@(posedge clk) disable iff (rst)
    enable && periodSourceSelect.matchEn && cnt_q == act_q.period |-> periodEvent)
    else $error("period match missed"); // [R17]

  cov_period: cover property (@(posedge clk) disable iff (rst) periodEvent);
  cov_rise_fall: cover property (@(posedge clk) disable iff (rst)
    risingAccepted ##[1:50] fallingAccepted);
  cov_shutdown: cover property (@(posedge clk) disable iff (rst) $rose(shutdown));
  cov_load: cover property (@(posedge clk) disable iff (rst) $fell(loadPending));

endmodule

// ==== dv/pwm_far_side.sv ====
// Purpose: Far-side model: comparator and pin sources plus the driven switches.
// Assumes: Bench commands each event level for exactly the cycles it wants.
// Notes:   A stuck shoot-through flag is kept so that a one-cycle overlap is not missed.
`timescale 1ns/1ps
module pwm_far_side
  import pwm_seq_pkg::*;
(
  input  wire logic        clk,          // Clock
  input  wire logic        rst,          // Synchronous reset
  input  wire asyncIn_type stim,         // Commanded pin and comparator levels
  input  wire logic [5:0]  drive,        // Switch drive from the block
  output asyncIn_type      asyncIn,      // Event lines into the block
  output logic             shootThrough  // Both switches of pair A/B seen on
);
  logic shoot_d;
  logic shoot_q;

  // Comparators are already synchronized, so the level follows the command.
  assign asyncIn = stim;

  // Series switches A and B must never conduct together.
  always_comb begin
    shoot_d = shoot_q | (drive[0] & drive[1]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shoot_q <= 1'b0;
    end else begin
      shoot_q <= shoot_d;
    end
  end

  assign shootThrough = shoot_q;
endmodule

// ==== dv/tb_pwm_event_seq.sv ====
// Purpose: Self-checking bench for the PWM event sequencer.
// Assumes: Single mode and no dead-band, except complementary mode with two clocks of dead-band in t_compl; no blanking; period 7, phase 2, duty 5.
// Notes:   Inputs change 1 ns after a rising edge; pulses are sampled at the falling edge.
`timescale 1ns/1ps
module tb_pwm_event_seq;
  import pwm_seq_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        bufferLoadRequest = 1'b0;
  logic        modEnable = 1'b0;
  logic        modSoftBit = 1'b1;
  asyncIn_type stim = '0;
  asyncIn_type asyncIn;
  asyncIn_type shutdownEnable = '0;
  mode_type    mode = MODE_SINGLE;
  logic [7:0]  deadBand = 8'h00;
  logic [15:0] timeBaseCounter;
  logic        loadPending, shutdown, periodEvent, risingAccepted, fallingAccepted;
  logic        shootThrough;
  logic [5:0]  drive;
  int          miscompares = 0;
  int          numChecks = 0;
  int          cycles = 0;

  pwm_event_seq i_pwm_event_seq (.clk(clk), .rst(rst), .enable(1'b1), .mode(mode),
    .timingIn({16'h0007, 16'h0002, 16'h0005}), .bufferLoadRequest(bufferLoadRequest),
    .periodSourceSelect(srcSel_type'(5'h18)), .risingSourceSelect(srcSel_type'(5'h11)),
    .fallingSourceSelect(srcSel_type'(5'h14)), .asyncIn(asyncIn),
    .shutdownEnable(shutdownEnable), .modEnable(modEnable), .modSelect(MOD_SOFT),
    .modSoftBit(modSoftBit), .captureCompareOut(1'b0), .deadBandCount(deadBand),
    .blankCount(8'h00), .timeBaseCounter(timeBaseCounter), .loadPending(loadPending),
    .shutdown(shutdown), .drive(drive), .periodEvent(periodEvent),
    .risingAccepted(risingAccepted), .fallingAccepted(fallingAccepted));

  pwm_far_side i_pwm_far_side (.clk(clk), .rst(rst), .stim(stim), .drive(drive),
    .asyncIn(asyncIn), .shootThrough(shootThrough));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bounded wait until the counter shows c just after an edge.
  task automatic wait_cnt(input logic [15:0] c);
    for (int i = 0; i < 40 && timeBaseCounter !== c; i++) begin
      @(posedge clk);
      #1;
    end
    chk("counter", c, timeBaseCounter);
  endtask

  // Hold stimulus for the one cycle where the counter is c and judge the pulses.
  task automatic poke(input logic [15:0] c, input logic [3:0] lv, input logic r, input logic f);
    wait_cnt(c);
    stim = asyncIn_type'(lv);
    @(negedge clk);
    chk("risingAccepted", {15'h0, r}, {15'h0, risingAccepted});
    chk("fallingAccepted", {15'h0, f}, {15'h0, fallingAccepted});
    @(posedge clk);
    #1;
    stim = '0;
  endtask

  task automatic t_load();
    @(posedge clk);
    #1;
    bufferLoadRequest = 1'b1;
    @(posedge clk);
    #1;
    bufferLoadRequest = 1'b0;
    chk("loadPending", 16'h1, {15'h0, loadPending});
    stim = asyncIn_type'(4'h8);
    @(negedge clk);
    chk("periodEvent", 16'h1, {15'h0, periodEvent});
    @(posedge clk);
    #1;
    stim = '0;
    chk("counter", 16'h0000, timeBaseCounter);
    @(posedge clk);
    #1;
    chk("counter", 16'h0001, timeBaseCounter);
    chk("loadPending", 16'h0, {15'h0, loadPending});
    $display("test load done");
  endtask

  task automatic t_walk();
    logic [15:0] c;
    wait_cnt(16'h0000);
    for (int i = 0; i < 16; i++) begin
      c = 16'(i % 8);
      @(negedge clk);
      chk("counter", c, timeBaseCounter);
      chk("periodEvent", {15'h0, c == 7}, {15'h0, periodEvent});
      chk("risingAccepted", {15'h0, c == 2}, {15'h0, risingAccepted});
      chk("fallingAccepted", {15'h0, c == 5}, {15'h0, fallingAccepted});
      chk("drive", {15'h0, c >= 4 && c < 7}, {15'h0, drive[0]});
    end
    $display("test walk done");
  endtask

  task automatic t_refuse();
    poke(16'h0003, 4'h1, 1'b0, 1'b0);
    poke(16'h0006, 4'h5, 1'b0, 1'b0);
    poke(16'h0000, 4'h1, 1'b1, 1'b0);
    poke(16'h0002, 4'h0, 1'b0, 1'b0);
    $display("test refuse done");
  endtask

  task automatic t_gate();
    wait_cnt(16'h0000);
    modEnable = 1'b1;
    modSoftBit = 1'b0;
    repeat (8) begin
      @(negedge clk);
      chk("drive", 16'h0, {15'h0, drive[0]});
    end
    @(posedge clk);
    #1;
    modEnable = 1'b0;
    modSoftBit = 1'b1;
    chk("shootThrough", 16'h0, {15'h0, shootThrough});
    $display("test gate done");
  endtask

  // Complementary pair with two clocks of dead time: A and B never overlap.
  task automatic t_compl();
    logic [15:0] c;
    logic [1:0]  e;
    wait_cnt(16'h0000);
    mode = MODE_COMPL;
    deadBand = 8'h02;
    for (int i = 0; i < 16; i++) begin
      c = 16'(i % 8);
      e = (c >= 1 && c <= 3) ? 2'b10 : ((c == 6) ? 2'b01 : 2'b00);
      @(negedge clk);
      chk("drivePair", {14'h0, e}, {14'h0, drive[1:0]});
    end
    @(posedge clk);
    #1;
    mode = MODE_SINGLE;
    deadBand = 8'h00;
    chk("shootThrough", 16'h0, {15'h0, shootThrough});
    $display("test complementary done");
  endtask

  task automatic t_shut();
    shutdownEnable = asyncIn_type'(4'h2);
    poke(16'h0001, 4'h2, 1'b0, 1'b0);
    @(posedge clk);
    #1;
    chk("shutdown", 16'h1, {15'h0, shutdown});
    repeat (10) begin
      @(negedge clk);
      chk("drive", 16'h0, {10'h0, drive});
    end
    $display("test shutdown done");
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_load();
    t_walk();
    t_refuse();
    t_gate();
    t_compl();
    t_shut();
    print_verdict();
  end
endmodule
